// *** flash_prog_erase_clock_cmds_tb.sv ***
// Self-checking bench: programmer and target joined by the link interface.
// Assumes shortened wait limits and erase time so the run stays short.
`timescale 1ns/100ps
`default_nettype none
module flash_prog_erase_clock_cmds_tb;
  import fpe_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_nrst    = 1'b0;
  logic        p_ce, t_ce, start, prot_whole, prot_range, active, done, erasing;
  logic [1:0]  fault;
  logic [7:0]  blk_a, blk_b, status;
  logic [31:0] freq, tgt_freq;
  fpe_op_t     op;
  fpe_result_t result;
  int          error_cnt = 0;
  int          total_checks = 0;
  logic [31:0] fq [4] = '{32'h000f423f, 32'h000f4240, 32'h01312d00, 32'h01312d01};
  logic [31:0] fq_keep [4] = '{32'h0, 32'h000f4240, 32'h01312d00, 32'h01312d00};
  logic [7:0]  fq_st [4] = '{8'h05, 8'h06, 8'h06, 8'h05};
  logic [7:0]  er_st [4] = '{8'h06, 8'h1c, 8'h1a, 8'h1b};

  fpe_link_if fpe_link_if_i ();
  fpe_programmer #(.FREQ_WAIT_CYC(3000), .CHIP_WAIT_CYC(3000),
    .BLOCK_WAIT_CYC(3000), .STATUS_WAIT_CYC(3000)) fpe_programmer_i (.i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst), .i_ce(p_ce), .i_start(start), .i_op(op), .i_freq(freq), .i_first_block(blk_a),
    .i_last_block(blk_b), .o_active(active), .o_done(done), .o_result(result), .o_status(status),
    .link(fpe_link_if_i));
  fpe_target #(.ERASE_CYC(50)) fpe_target_i (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ce(t_ce),
    .i_protect_whole(prot_whole), .i_protect_range(prot_range), .i_erase_fault(fault),
    .o_freq(tgt_freq), .o_erasing(erasing), .link(fpe_link_if_i));
  fpe_link_monitor fpe_link_monitor_i (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .link_clk(fpe_link_if_i.link_clk), .cmd_data(fpe_link_if_i.cmd_data),
    .reply_data(fpe_link_if_i.reply_data), .busy_handshake_line(fpe_link_if_i.busy_handshake_line));

  // Free-running system clock.
  always #5 i_sys_clk = ~i_sys_clk;

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task results;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Bounded wait on a flag, sampled at falling edges; running out ends the run.
  task automatic wait_for(ref logic flag);
    int n;
    for (n = 0; n < 20000 && flag !== 1'b1; n++) @(negedge i_sys_clk);
    if (flag !== 1'b1) begin
      error_cnt++;
      results();
    end
  endtask

  // Starts one sequence; the start pulse lasts one cycle.
  task automatic launch(input fpe_op_t o, input logic [31:0] f, input logic [7:0] a, input logic [7:0] b);
    op = o;
    freq = f;
    blk_a = a;
    blk_b = b;
    start = 1'b1;
    @(negedge i_sys_clk);
    start = 1'b0;
  endtask

  // Runs a sequence to completion; acknowledge alone means normal completion.
  task automatic run(input fpe_op_t o, input logic [31:0] f, input logic [7:0] a, input logic [7:0] b,
                     input logic [7:0] st);
    launch(o, f, a, b);
    wait_for(done);
    chk_val({30'h0, result}, (st == 8'h06) ? 32'h0 : 32'h1);
    chk_val({24'h0, status}, {24'h0, st});
  endtask

  initial begin
    {p_ce, t_ce} = 2'b11;
    {start, prot_whole, prot_range} = 3'b000;
    fault = 2'h0;
    launch(FPE_OP_FREQ_SET, 32'h0, 8'h00, 8'h00);
    repeat (9) @(negedge i_sys_clk);
    i_nrst = 1'b1;
    chk_val({27'h0, fpe_link_if_i.link_clk, fpe_link_if_i.busy_handshake_line, active, done, erasing}, 32'h0);
    // Clock set at both range edges and just outside them.
    for (int i = 0; i < 4; i++) begin
      run(FPE_OP_FREQ_SET, fq[i], 8'h00, 8'h00, fq_st[i]);
      chk_val(tgt_freq, fq_keep[i]);
    end
    // The zero filler byte of each status read is a zero-length frame, which the target refuses.
    run(fpe_op_t'(2'b11), 32'h0, 8'h00, 8'h00, 8'h15);
    // Whole erase with every fault kind, then refused by protection.
    for (int i = 0; i < 4; i++) begin
      fault = 2'(i);
      run(FPE_OP_WHOLE_ERASE, 32'h0, 8'h00, 8'h00, er_st[i]);
    end
    fault = 2'h0;
    prot_whole = 1'b1;
    run(FPE_OP_WHOLE_ERASE, 32'h0, 8'h00, 8'h00, 8'h10);
    prot_whole = 1'b0;
    // Range erase over three blocks, a failing range, a protected range.
    run(FPE_OP_RANGE_ERASE, 32'h0, 8'h00, 8'h02, 8'h06);
    fault = 2'h1;
    run(FPE_OP_RANGE_ERASE, 32'h0, 8'h03, 8'h05, 8'h1a);
    fault = 2'h0;
    prot_range = 1'b1;
    run(FPE_OP_RANGE_ERASE, 32'h0, 8'h03, 8'h05, 8'h10);
    prot_range = 1'b0;
    // Target frozen mid-erase keeps busy up, so the wait limit must expire.
    launch(FPE_OP_WHOLE_ERASE, 32'h0, 8'h00, 8'h00);
    wait_for(erasing);
    t_ce = 1'b0;
    wait_for(done);
    chk_val({30'h0, result}, 32'h2);
    chk_val({24'h0, status}, 32'h10);
    t_ce = 1'b1;
    // Recovery: the next command waits out the erase, then completes.
    run(FPE_OP_FREQ_SET, 32'h000f4240, 8'h00, 8'h00, 8'h06);
    results();
  end
endmodule
`default_nettype wire

// *** fpe_link_if.sv ***
// Three-wire serial link plus busy handshake line between the two ends.
// Assumes the bench joins one programmer end and one target end to it.
`timescale 1ns/100ps
`default_nettype none
interface fpe_link_if;
  logic link_clk;
  logic cmd_data;
  logic reply_data;
  logic busy_handshake_line;
  modport prog (output link_clk, output cmd_data, input reply_data, input busy_handshake_line);
  modport tgt (input link_clk, input cmd_data, output reply_data, output busy_handshake_line);
endinterface
`default_nettype wire

// *** fpe_link_monitor.sv ***
// Checker for the serial link and busy line between the two ends.
// Assumes one clock domain and that link timing follows HALF_CYC of 8.
`timescale 1ns/100ps
`default_nettype none
module fpe_link_monitor #(
  parameter int unsigned HALF_CYC = 8
) (
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  input  wire logic link_clk,
  input  wire logic cmd_data,
  input  wire logic reply_data,
  input  wire logic busy_handshake_line
);
  logic [7:0] lo_cnt;
  logic [7:0] hi_cnt;
  logic [2:0] bit_cnt;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  // Low phase length; saturates so a long idle never wraps back into range.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst || link_clk) lo_cnt <= 8'h00;
    else if (lo_cnt != 8'hff) lo_cnt <= lo_cnt + 8'h01;
  end

  // High phase length.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst || !link_clk) hi_cnt <= 8'h00;
    else if (hi_cnt != 8'hff) hi_cnt <= hi_cnt + 8'h01;
  end

  // Bits sent since reset; whole frames keep it a multiple of eight.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) bit_cnt <= 3'h0;
    else if (link_clk && hi_cnt == 8'h00) bit_cnt <= bit_cnt + 3'h1;
  end

  property p_high_phase;
    $fell(link_clk) |-> hi_cnt == 8'(HALF_CYC);
  endproperty
  a_high_phase: assert property (p_high_phase) else $error("link clock high phase wrong");
  // Inside a byte the low phase is exact; between bytes the engine spends a done and a load cycle.
  property p_low_phase;
    $rose(link_clk) |-> lo_cnt == 8'(HALF_CYC) || lo_cnt >= 8'(HALF_CYC + 2);
  endproperty
  a_low_phase: assert property (p_low_phase) else $error("link clock low phase wrong");
  property p_cmd_hold;
    $rose(link_clk) |-> ##1 $stable(cmd_data)[*7];
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command bit moved while clock high");
  property p_reply_hold;
    link_clk && $past(link_clk) |-> $stable(reply_data);
  endproperty
  a_reply_hold: assert property (p_reply_hold) else $error("reply bit moved while clock high");
  property p_frame_bytes;
    $rose(link_clk) && lo_cnt > 8'h10 |-> bit_cnt == 3'h0;
  endproperty
  a_frame_bytes: assert property (p_frame_bytes) else $error("frame not whole bytes");
  property p_no_send_busy;
    $rose(link_clk) && lo_cnt > 8'h10 |-> !busy_handshake_line;
  endproperty
  a_no_send_busy: assert property (p_no_send_busy) else $error("frame started while busy");
  property p_busy_after_frame;
    $rose(busy_handshake_line) |-> lo_cnt < 8'h28;
  endproperty
  a_busy_after_frame: assert property (p_busy_after_frame) else $error("busy rose without a frame");
  property p_reply_idle;
    lo_cnt > 8'h10 |-> $stable(reply_data);
  endproperty
  a_reply_idle: assert property (p_reply_idle) else $error("reply moved on idle link");

  // Frame starts, erase ends and long busy spells are reached.
  c_frame: cover property ($rose(link_clk) && lo_cnt > 8'h10);
  c_busy_end: cover property ($fell(busy_handshake_line));
  c_busy_long: cover property (busy_handshake_line[*8]);
endmodule
`default_nettype wire

// *** fpe_map.svh ***
// Constants of the erase and clock-set link: codes, frame lengths, timing.
// Assumes a 100 MHz system clock on both ends; included by the package users.
`ifndef FPE_MAP_SVH
`define FPE_MAP_SVH

// Status codes returned in the first status byte.
`define FPE_ST_CMD_ERR       8'h04
`define FPE_ST_PARAM         8'h05
`define FPE_ST_ACK           8'h06
`define FPE_ST_CHKSUM        8'h07
`define FPE_ST_PROTECT       8'h10
`define FPE_ST_NACK          8'h15
`define FPE_ST_ERASE_MARGIN  8'h1a
`define FPE_ST_VERIFY_MARGIN 8'h1b
`define FPE_ST_WRITE         8'h1c

// Command codes and the frame end marker.
`define FPE_CODE_FREQ_SET    8'h90
`define FPE_CODE_WHOLE_ERASE 8'h20
`define FPE_CODE_RANGE_ERASE 8'h22
`define FPE_CODE_STATUS      8'h70
`define FPE_ETX              8'h03

// Length field values: command byte plus parameters.
`define FPE_LEN_FREQ_SET     8'h05
`define FPE_LEN_WHOLE_ERASE  8'h01
`define FPE_LEN_RANGE_ERASE  8'h07
`define FPE_LEN_STATUS       8'h01
`define FPE_LEN_MAX          8'h07

// Timing: wait limits in microseconds, converted to cycles by the programmer.
`define FPE_CLK_PERIOD_NS    10
`define FPE_CMD_WAIT_MAX_US  100
`define FPE_FREQ_WAIT_MAX_US 1000
`define FPE_CHIP_WAIT_MAX_US 1000000
`define FPE_BLK_WAIT_MAX_US  100000
`define FPE_STAT_WAIT_MAX_US 1000
`define FPE_LINK_HALF_CYC    8
`define FPE_GUARD_CYC        16
`define FPE_ERASE_CYC        1000
`define FPE_BLOCK_BITS       12
`define FPE_FREQ_MIN         32'h000f4240
`define FPE_FREQ_MAX         32'h01312d00

`endif

// *** fpe_pkg.sv ***
// Types shared by both ends of the erase and clock-set link.
// Assumes nothing of its surroundings.
`default_nettype none
package fpe_pkg;
  typedef enum logic [1:0] {
    FPE_OP_FREQ_SET    = 2'b00,
    FPE_OP_WHOLE_ERASE = 2'b01,
    FPE_OP_RANGE_ERASE = 2'b10
  } fpe_op_t;
  typedef enum logic [1:0] {
    FPE_RES_NORMAL   = 2'b00,
    FPE_RES_ABNORMAL = 2'b01,
    FPE_RES_TIMEOUT  = 2'b10
  } fpe_result_t;
  typedef enum logic [2:0] {
    FPE_S_IDLE = 3'b000,
    FPE_S_PRE  = 3'b001,
    FPE_S_SEND = 3'b010,
    FPE_S_POST = 3'b011,
    FPE_S_RECV = 3'b100
  } fpe_state_t;
endpackage
`default_nettype wire

// *** fpe_programmer.sv ***
// Programmer end: runs clock-set, whole erase and range erase sequences
// with busy waits, status fetch and time-outs. Assumes the busy and reply
// pins come from another clock domain; it makes the link clock itself.
// Behaviour
// - Wait not-busy before command, bounded, else time-out.
// - After clock set, bounded busy wait, then status.
// - Clock-set frame carries four data bytes, length five.
// - Target acknowledges accepted clock, parameter error otherwise.
// - Target reports checksum error on mismatched frame.
// - Target refuses busy-time or malformed frames with NACK.
// - Whole erase has no parameters, bounded wait, status.
// - Target rejects protected whole erase with protect error.
// - Failed whole erase reports write or margin error.
// - Range erase sends start and end, length seven.
// - Erase next block until all done, then normal.
// - Target: unaligned range parameter error, protected range refused.
// - Failed range erase reports the first margin error.
// - Acknowledge normal, other status abnormal, late status time-out.
// - Busy past the limit is a time-out outcome.
// - Status check sends status command, inspects first byte.
`timescale 1ns/100ps
`default_nettype none
`include "fpe_map.svh"
module fpe_programmer
  import fpe_pkg::*;
#(
  parameter int unsigned HALF_CYC        = `FPE_LINK_HALF_CYC,
  parameter int unsigned BLOCK_BITS      = `FPE_BLOCK_BITS,
  parameter int unsigned CMD_WAIT_CYC    = `FPE_CMD_WAIT_MAX_US * 1000 / `FPE_CLK_PERIOD_NS,
  parameter int unsigned FREQ_WAIT_CYC   = `FPE_FREQ_WAIT_MAX_US * 1000 / `FPE_CLK_PERIOD_NS,
  parameter int unsigned CHIP_WAIT_CYC   = `FPE_CHIP_WAIT_MAX_US * 1000 / `FPE_CLK_PERIOD_NS,
  parameter int unsigned BLOCK_WAIT_CYC  = `FPE_BLK_WAIT_MAX_US * 1000 / `FPE_CLK_PERIOD_NS,
  parameter int unsigned STATUS_WAIT_CYC = `FPE_STAT_WAIT_MAX_US * 1000 / `FPE_CLK_PERIOD_NS
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  input  wire logic        i_start,
  input  wire fpe_op_t     i_op,
  input  wire logic [31:0] i_freq,
  input  wire logic [7:0]  i_first_block,
  input  wire logic [7:0]  i_last_block,
  output logic             o_active,
  output logic             o_done,
  output fpe_result_t      o_result,
  output logic [7:0]       o_status,
  fpe_link_if.prog         link
);
  fpe_state_t  state;
  fpe_op_t     op;
  logic        phase;
  logic [31:0] freq, tmo, limit;
  logic [7:0]  cur_blk, last_blk;
  logic [3:0]  bidx;
  logic        busy_q1, busy_q2, rx_q1, rx_q2;
  logic        eng_run, eng_done, eng_load, tmo_hit, guard_ok;
  logic [7:0]  tx_sh, rx_sh, div_cnt, eng_byte, fchk;
  logic [2:0]  bitn;
  logic [7:0]  body  [0:7];
  logic [7:0]  frame [0:9];
  logic [23:0] blk_start, blk_end;

  // Busy and reply pins pass two flops before any logic reads them.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      {busy_q1, busy_q2, rx_q1, rx_q2} <= 4'h0;
    end else if (i_ce) begin
      {busy_q2, busy_q1, rx_q2, rx_q1} <= {busy_q1, link.busy_handshake_line, rx_q1, link.reply_data};
    end
  end

  // Range erase covers exactly one block per command.
  assign blk_start = 24'(cur_blk) << BLOCK_BITS;
  assign blk_end   = blk_start | ((24'h000001 << BLOCK_BITS) - 24'h000001);

  // Frame builder: length, command, parameters, checksum, end marker.
  always_comb begin
    for (int i = 0; i < 8; i++) body[i] = 8'h00;
    body[0] = `FPE_LEN_STATUS;
    body[1] = `FPE_CODE_STATUS;
    if (!phase) begin
      unique case (op)
        FPE_OP_FREQ_SET: begin
          body[0] = `FPE_LEN_FREQ_SET;
          body[1] = `FPE_CODE_FREQ_SET;
          {body[2], body[3], body[4], body[5]} = freq;
        end
        FPE_OP_WHOLE_ERASE: begin
          body[0] = `FPE_LEN_WHOLE_ERASE;
          body[1] = `FPE_CODE_WHOLE_ERASE;
        end
        FPE_OP_RANGE_ERASE: begin
          body[0] = `FPE_LEN_RANGE_ERASE;
          body[1] = `FPE_CODE_RANGE_ERASE;
          {body[2], body[3], body[4]} = blk_start;
          {body[5], body[6], body[7]} = blk_end;
        end
        default: ;
      endcase
    end
    fchk = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (8'(i) <= body[0]) fchk = fchk - body[i];
    end
    for (int i = 0; i < 10; i++) frame[i] = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (8'(i) <= body[0]) frame[i] = body[i];
    end
    frame[4'(body[0] + 8'h01)] = fchk;
    frame[4'(body[0] + 8'h02)] = `FPE_ETX;
  end

  // A byte starts whenever the sequencer sits in a transfer state idle.
  assign eng_load = ((state == FPE_S_SEND) || (state == FPE_S_RECV)) && !eng_run && !eng_done;
  assign eng_byte = (state == FPE_S_RECV) ? 8'h00 : frame[bidx];

  // Byte engine: divides the system clock into the link clock, sends MSB
  // first on the falling edge and samples the reply on the rising edge.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      eng_run       <= 1'b0;
      eng_done      <= 1'b0;
      link.link_clk <= 1'b0;
      link.cmd_data <= 1'b0;
      tx_sh         <= 8'h00;
      rx_sh         <= 8'h00;
      bitn          <= 3'h0;
      div_cnt       <= 8'h00;
    end else if (i_ce) begin
      eng_done <= 1'b0;
      if (eng_load) begin
        eng_run       <= 1'b1;
        tx_sh         <= eng_byte;
        link.cmd_data <= eng_byte[7];
        bitn          <= 3'h0;
        div_cnt       <= 8'h00;
      end else if (eng_run) begin
        if (div_cnt == 8'(HALF_CYC - 1)) begin
          div_cnt <= 8'h00;
          if (!link.link_clk) begin
            link.link_clk <= 1'b1;
            rx_sh         <= {rx_sh[6:0], rx_q2};
          end else begin
            link.link_clk <= 1'b0;
            if (bitn == 3'h7) begin
              eng_run  <= 1'b0;
              eng_done <= 1'b1;
            end else begin
              bitn          <= bitn + 3'h1;
              tx_sh         <= {tx_sh[6:0], 1'b0};
              link.cmd_data <= tx_sh[6];
            end
          end
        end else begin
          div_cnt <= div_cnt + 8'h01;
        end
      end
    end
  end

  // Wait limit for the current busy check.
  always_comb begin
    if (state == FPE_S_PRE) begin
      limit = 32'(CMD_WAIT_CYC);
    end else if (phase) begin
      limit = 32'(STATUS_WAIT_CYC);
    end else begin
      unique case (op)
        FPE_OP_WHOLE_ERASE: limit = 32'(CHIP_WAIT_CYC);
        FPE_OP_RANGE_ERASE: limit = 32'(BLOCK_WAIT_CYC);
        default:            limit = 32'(FREQ_WAIT_CYC);
      endcase
    end
  end

  // Time-out counter runs only in busy checks; leaving one clears it.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      tmo <= 32'h00000000;
    end else if (i_ce) begin
      tmo <= (state == FPE_S_PRE || state == FPE_S_POST) ? tmo + 32'h00000001 : 32'h00000000;
    end
  end
  assign tmo_hit = (tmo >= limit);
  // The guard hides the stale not-busy seen just after a frame goes out.
  assign guard_ok = (tmo >= 32'(`FPE_GUARD_CYC));

  // Sequencer: busy check, command, busy check, status frame, busy check, status byte.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      state    <= FPE_S_IDLE;
      op       <= FPE_OP_FREQ_SET;
      phase    <= 1'b0;
      freq     <= 32'h00000000;
      cur_blk  <= 8'h00;
      last_blk <= 8'h00;
      bidx     <= 4'h0;
      o_done   <= 1'b0;
      o_result <= FPE_RES_NORMAL;
      o_status <= 8'h00;
    end else if (i_ce) begin
      o_done <= 1'b0;
      unique case (state)
        FPE_S_IDLE: begin
          if (i_start) begin
            op       <= i_op;
            freq     <= i_freq;
            cur_blk  <= i_first_block;
            last_blk <= i_last_block;
            phase    <= 1'b0;
            state    <= FPE_S_PRE;
          end
        end
        FPE_S_PRE: begin
          if (!busy_q2) begin
            bidx  <= 4'h0;
            state <= FPE_S_SEND;
          end else if (tmo_hit) begin
            o_result <= FPE_RES_TIMEOUT;
            o_done   <= 1'b1;
            state    <= FPE_S_IDLE;
          end
        end
        FPE_S_SEND: begin
          if (eng_done) begin
            bidx <= bidx + 4'h1;
            if ({4'h0, bidx} == body[0] + 8'h02) begin
              state <= FPE_S_POST;
            end
          end
        end
        FPE_S_POST: begin
          if (guard_ok && !busy_q2) begin
            if (phase) begin
              state <= FPE_S_RECV;
            end else begin
              phase <= 1'b1;
              bidx  <= 4'h0;
              state <= FPE_S_SEND;
            end
          end else if (tmo_hit) begin
            o_result <= FPE_RES_TIMEOUT;
            o_done   <= 1'b1;
            state    <= FPE_S_IDLE;
          end
        end
        FPE_S_RECV: begin
          if (eng_done) begin
            o_status <= rx_sh;
            phase    <= 1'b0;
            if (rx_sh != `FPE_ST_ACK) begin
              o_result <= FPE_RES_ABNORMAL;
              o_done   <= 1'b1;
              state    <= FPE_S_IDLE;
            end else if (op == FPE_OP_RANGE_ERASE && cur_blk < last_blk) begin
              cur_blk <= cur_blk + 8'h01;
              state   <= FPE_S_PRE;
            end else begin
              o_result <= FPE_RES_NORMAL;
              o_done   <= 1'b1;
              state    <= FPE_S_IDLE;
            end
          end
        end
        default: state <= FPE_S_IDLE;
      endcase
    end
  end

  assign o_active = (state != FPE_S_IDLE);
endmodule
`default_nettype wire

// *** fpe_target.sv ***
// Target end: receives command frames, checks them, runs erases and
// answers status. Assumes link pins come from another clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "fpe_map.svh"
module fpe_target
  import fpe_pkg::*;
#(
  parameter int unsigned ERASE_CYC  = `FPE_ERASE_CYC,
  parameter int unsigned BLOCK_BITS = `FPE_BLOCK_BITS,
  parameter logic [31:0] FREQ_MIN   = `FPE_FREQ_MIN,
  parameter logic [31:0] FREQ_MAX   = `FPE_FREQ_MAX
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  input  wire logic        i_protect_whole,
  input  wire logic        i_protect_range,
  input  wire logic [1:0]  i_erase_fault,
  output logic [31:0]      o_freq,
  output logic             o_erasing,
  fpe_link_if.tgt          link
);
  logic        clk_q1, clk_q2, clk_q3, dat_q1, dat_q2;
  logic        rise, fall, byte_ok;
  logic [2:0]  bitc;
  logic [6:0]  rx_sh;
  logic [7:0]  rx_byte, tsh, reply, res, flen, sum;
  logic [3:0]  idx;
  logic [7:0]  body [1:7];
  logic        chk_ok, etx_ok, frm_end, frm_bad, busy, whole;
  logic [31:0] ecnt, fval;
  logic [23:0] sa, ea, mask;
  logic        aligned;

  // Link pins pass two flops; the third flop only serves edge finding.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      {clk_q1, clk_q2, clk_q3, dat_q1, dat_q2} <= 5'h00;
    end else if (i_ce) begin
      {clk_q3, clk_q2, clk_q1} <= {clk_q2, clk_q1, link.link_clk};
      {dat_q2, dat_q1} <= {dat_q1, link.cmd_data};
    end
  end

  assign rise    = clk_q2 & ~clk_q3;
  assign fall    = ~clk_q2 & clk_q3;
  assign byte_ok = rise && (bitc == 3'h7);
  assign rx_byte = {rx_sh, dat_q2};

  // Command bits are taken on the rising link clock, MSB first.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      bitc  <= 3'h0;
      rx_sh <= 7'h00;
    end else if (i_ce && rise) begin
      rx_sh <= {rx_sh[5:0], dat_q2};
      bitc  <= bitc + 3'h1;
    end
  end

  // Reply bits change on the falling clock; a byte boundary loads the reply.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      tsh <= 8'h00;
    end else if (i_ce && fall) begin
      tsh <= (bitc == 3'h0) ? reply : {tsh[6:0], 1'b0};
    end
  end
  assign link.reply_data = tsh[7];

  // Frame parser: length, body, checksum, end marker.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      idx     <= 4'h0;
      flen    <= 8'h00;
      sum     <= 8'h00;
      chk_ok  <= 1'b0;
      etx_ok  <= 1'b0;
      frm_end <= 1'b0;
      frm_bad <= 1'b0;
      for (int i = 1; i < 8; i++) body[i] <= 8'h00;
    end else if (i_ce) begin
      frm_end <= 1'b0;
      frm_bad <= 1'b0;
      if (byte_ok) begin
        if (idx == 4'h0) begin
          flen <= rx_byte;
          sum  <= rx_byte;
          if (rx_byte == 8'h00 || rx_byte > `FPE_LEN_MAX) begin
            frm_bad <= 1'b1;
          end else begin
            idx <= 4'h1;
          end
        end else if ({4'h0, idx} <= flen) begin
          body[idx] <= rx_byte;
          sum       <= sum + rx_byte;
          idx       <= idx + 4'h1;
        end else if ({4'h0, idx} == flen + 8'h01) begin
          chk_ok <= (sum + rx_byte) == 8'h00;
          idx    <= idx + 4'h1;
        end else begin
          etx_ok  <= (rx_byte == `FPE_ETX);
          frm_end <= 1'b1;
          idx     <= 4'h0;
        end
      end
    end
  end

  // Parameter decode for the range and frequency checks.
  assign fval    = {body[2], body[3], body[4], body[5]};
  assign sa      = {body[2], body[3], body[4]};
  assign ea      = {body[5], body[6], body[7]};
  assign mask    = (24'h000001 << BLOCK_BITS) - 24'h000001;
  assign aligned = ((sa & mask) == 24'h000000) && ((ea & mask) == mask) && (sa <= ea);

  // Executes frames; an erase in progress holds the busy line high.
  // The erase end is written last so its result wins a same-cycle frame.
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      res    <= `FPE_ST_ACK;
      reply  <= 8'h00;
      busy   <= 1'b0;
      whole  <= 1'b0;
      ecnt   <= 32'h00000000;
      o_freq <= 32'h00000000;
    end else if (i_ce) begin
      if (frm_bad || (frm_end && !etx_ok)) begin
        res <= `FPE_ST_NACK;
      end else if (frm_end && !chk_ok) begin
        res <= `FPE_ST_CHKSUM;
      end else if (frm_end && body[1] == `FPE_CODE_STATUS && flen == `FPE_LEN_STATUS) begin
        reply <= res;
      end else if (frm_end && busy) begin
        res <= `FPE_ST_NACK;
      end else if (frm_end) begin
        unique case (body[1])
          `FPE_CODE_FREQ_SET: begin
            if (flen != `FPE_LEN_FREQ_SET) begin
              res <= `FPE_ST_NACK;
            end else if (fval < FREQ_MIN || fval > FREQ_MAX) begin
              res <= `FPE_ST_PARAM;
            end else begin
              o_freq <= fval;
              res    <= `FPE_ST_ACK;
            end
          end
          `FPE_CODE_WHOLE_ERASE: begin
            if (flen != `FPE_LEN_WHOLE_ERASE) begin
              res <= `FPE_ST_NACK;
            end else if (i_protect_whole) begin
              res <= `FPE_ST_PROTECT;
            end else begin
              busy  <= 1'b1;
              whole <= 1'b1;
              ecnt  <= 32'(ERASE_CYC - 1);
            end
          end
          `FPE_CODE_RANGE_ERASE: begin
            if (flen != `FPE_LEN_RANGE_ERASE) begin
              res <= `FPE_ST_NACK;
            end else if (!aligned) begin
              res <= `FPE_ST_PARAM;
            end else if (i_protect_range) begin
              res <= `FPE_ST_PROTECT;
            end else begin
              busy  <= 1'b1;
              whole <= 1'b0;
              ecnt  <= 32'(ERASE_CYC - 1);
            end
          end
          default: res <= `FPE_ST_CMD_ERR;
        endcase
      end
      if (busy) begin
        if (ecnt == 32'h00000000) begin
          busy <= 1'b0;
          if (!whole) begin
            res <= (i_erase_fault == 2'b00) ? `FPE_ST_ACK : `FPE_ST_ERASE_MARGIN;
          end else begin
            unique case (i_erase_fault)
              2'b00: res <= `FPE_ST_ACK;
              2'b01: res <= `FPE_ST_WRITE;
              2'b10: res <= `FPE_ST_ERASE_MARGIN;
              2'b11: res <= `FPE_ST_VERIFY_MARGIN;
            endcase
          end
        end else begin
          ecnt <= ecnt - 32'h00000001;
        end
      end
    end
  end

  assign link.busy_handshake_line = busy;
  assign o_erasing                = busy;
endmodule
`default_nettype wire
